//--- hw/csp_chuff_select.sv
/*
 * Chuff set selection interpreter: handles the sound adjustment pseudo-write
 * that enters the procedure and the F0..F8 commands inside it.
 * Assumes writes arrive as one-cycle strobes from the packet decoder, that
 * power loss is seen as rstn_i, and that sound playback lives elsewhere.
 */
// Contract
// - Writing 100 to the sound adjustment variable starts the procedure.
// - Only steam sound projects may start chuff selection.
// - Procedures work only when the locomotive address is not 3.
// - The entry write is a trigger and is never stored.
// - While active, F0..F8 are commands and drive no outputs.
// - F0 plays the selected chuff only at standstill.
// - F1/F2 step previous/next; play at standstill, substitute while moving.
// - F3 ends and clears the chuff selection; other sounds stay.
// - F8 ends and makes the chosen set active.
// - Any other programming write or power loss aborts, keeping old set; here a reset loads SEL_RESET instead.
// - Error jingle when stepping hits the end of the list.
// - Error jingle when F0 finds no assigned chuff sample.
// - Error jingle for keys with no meaning, such as F4 or F5.
// - Confirmation jingle after ending with F3 or F8.
// - Speed, direction and manual override keep working; functions wait.
module csp_chuff_select #(
    parameter int NUM_SETS = 5
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Decoded operations- or service-mode programming write
    input wire logic ops_write_i,
    input wire logic service_write_i,
    input wire logic [csp_pkg::CV_W-1:0] write_cv_i,
    input wire logic [7:0] write_value_i,
    input wire logic [csp_pkg::ADDR_W-1:0] loco_addr_i,
    // Project and drive state
    input wire logic project_is_steam_i,
    input wire logic moving_i,
    input wire logic [csp_pkg::NSETS_W-1:0] stored_sets_i,
    // Cab function keys and drive commands
    input wire logic [csp_pkg::NFUNCS-1:0] func_keys_i,
    input wire logic [7:0] speed_cmd_i,
    input wire logic dir_cmd_i,
    input wire logic manual_override_key_i,
    // Drive and function outputs
    output logic [csp_pkg::NFUNCS-1:0] func_out_o,
    output logic [7:0] speed_o,
    output logic dir_o,
    output logic manual_override_o,
    // Sound control
    output logic active_o,
    output logic [csp_pkg::NSETS_W-1:0] active_set_o,
    output logic [csp_pkg::NSETS_W-1:0] trial_set_o,
    output logic play_trial_o,
    output logic [1:0] jingle_o
);
    // The set counter is NSETS_W bits wide and set 0 means cleared.
    if (NUM_SETS < 1 || NUM_SETS > 31) begin : g_bad_sets
        $error("NUM_SETS must be 1 to 31");
    end

    localparam logic [csp_pkg::NSETS_W-1:0] MAX_SET = csp_pkg::NSETS_W'(NUM_SETS);

    logic active_reg;
    logic [csp_pkg::NSETS_W-1:0] active_set_reg;
    logic [csp_pkg::NSETS_W-1:0] trial_reg;
    logic play_reg;
    csp_pkg::csp_jingle_t jingle_reg;
    logic [csp_pkg::NFUNCS-1:0] func_out_reg;
    logic [7:0] speed_reg;
    logic dir_reg;
    logic man_reg;
    logic [csp_pkg::NKEYS-1:0] press;
    logic [csp_pkg::NSETS_W-1:0] nsets;
    logic entry_ok;
    logic abort;
    logic any_press;
    logic at_first;
    logic at_last;
    logic valid_key;

    genvar gk;
    generate
        for (gk = 0; gk < csp_pkg::NKEYS; gk++) begin : g_key
            csp_key_edge u_edge (
                .mclk_i(mclk_i),
                .rstn_i(rstn_i),
                .key_i(func_keys_i[gk]),
                .press_o(press[gk])
            );
        end
    endgenerate

    // The project may hold fewer sets than the decoder can address.
    assign nsets = (stored_sets_i > MAX_SET) ? MAX_SET : stored_sets_i;

    // A barred address or a non-steam project simply ignores the entry write.
    assign entry_ok = ops_write_i && (write_cv_i == csp_pkg::SOUND_ADJUST_CV)
        && (write_value_i == csp_pkg::ENTRY_VALUE)
        && project_is_steam_i
        && (loco_addr_i != csp_pkg::BARRED_ADDR);

    // Service mode writes count as other programming and also abort.
    assign abort = active_reg && ((ops_write_i && !entry_ok) || service_write_i);

    assign any_press = |press;
    assign at_first = (trial_reg <= csp_pkg::SEL_RESET);
    assign at_last = (trial_reg >= nsets);
    assign valid_key = press[csp_pkg::KEY_PLAY] | press[csp_pkg::KEY_PREV]
        | press[csp_pkg::KEY_NEXT] | press[csp_pkg::KEY_CLEAR] | press[csp_pkg::KEY_STORE];

    // Procedure mode. The entry value itself is never written anywhere.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_reg <= 1'b0;
        end else if (abort) begin
            active_reg <= 1'b0;
        end else if (!active_reg && entry_ok) begin
            active_reg <= 1'b1;
        end else if (active_reg && (press[csp_pkg::KEY_CLEAR] || press[csp_pkg::KEY_STORE])) begin
            active_reg <= 1'b0;
        end
    end

    // Committed chuff set; a reset stands for power loss and restores the default.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_set_reg <= csp_pkg::SEL_RESET;
        end else if (active_reg && !abort) begin
            if (press[csp_pkg::KEY_CLEAR]) begin
                active_set_reg <= csp_pkg::SEL_NONE;
            end else if (press[csp_pkg::KEY_STORE]) begin
                active_set_reg <= trial_reg;
            end
        end
    end

    // Trial set walked by F1/F2. Lower keys win when several rise together.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trial_reg <= csp_pkg::SEL_RESET;
        end else if (!active_reg && entry_ok) begin
            trial_reg <= active_set_reg;
        end else if (active_reg && !abort) begin
            if (press[csp_pkg::KEY_PREV] && !at_first) begin
                trial_reg <= trial_reg - 5'h01;
            end else if (!press[csp_pkg::KEY_PREV] && press[csp_pkg::KEY_NEXT] && !at_last) begin
                trial_reg <= trial_reg + 5'h01;
            end
        end
    end

    // One-cycle request to audition the trial set while stopped.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            play_reg <= 1'b0;
        end else begin
            play_reg <= active_reg && !abort && !moving_i
                && ((press[csp_pkg::KEY_PLAY] && trial_reg != csp_pkg::SEL_NONE)
                || (press[csp_pkg::KEY_PREV] && !at_first)
                || (press[csp_pkg::KEY_NEXT] && !at_last));
        end
    end

    // One-cycle jingle request.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_NONE;
        end else if (!active_reg || abort || !any_press) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_NONE;
        end else if (press[csp_pkg::KEY_CLEAR] || press[csp_pkg::KEY_STORE]) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_CONFIRM;
        end else if (!valid_key) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_ERROR;
        end else if (press[csp_pkg::KEY_PLAY] && trial_reg == csp_pkg::SEL_NONE) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_ERROR;
        end else if ((press[csp_pkg::KEY_PREV] && at_first)
                || (!press[csp_pkg::KEY_PREV] && press[csp_pkg::KEY_NEXT] && at_last)) begin
            jingle_reg <= csp_pkg::CSP_JINGLE_ERROR;
        end else begin
            jingle_reg <= csp_pkg::CSP_JINGLE_NONE;
        end
    end

    // Function outputs freeze during the procedure and follow the keys again
    // from the cycle after it ends.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            func_out_reg <= '0;
        end else if (!active_reg) begin
            func_out_reg <= func_keys_i;
        end
    end

    // Drive commands always pass.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_reg <= 8'h00;
            dir_reg <= 1'b0;
            man_reg <= 1'b0;
        end else begin
            speed_reg <= speed_cmd_i;
            dir_reg <= dir_cmd_i;
            man_reg <= manual_override_key_i;
        end
    end

    assign active_o = active_reg;
    assign active_set_o = active_set_reg;
    // While moving the trial set replaces the running chuff at once.
    assign trial_set_o = trial_reg;
    assign play_trial_o = play_reg;
    assign jingle_o = jingle_reg;
    assign func_out_o = func_out_reg;
    assign speed_o = speed_reg;
    assign dir_o = dir_reg;
    assign manual_override_o = man_reg;

    entry_steam_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!active_reg && ops_write_i && !project_is_steam_i) |=> !active_reg)
        else $error("procedure entered for non-steam project");
    entry_addr_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!active_reg && loco_addr_i == csp_pkg::BARRED_ADDR) |=> !active_reg)
        else $error("procedure entered at barred address");
    entry_ok_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!active_reg && entry_ok) |=> active_reg && trial_reg == $past(active_set_reg))
        else $error("valid entry write ignored");
    func_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && $past(active_reg)) |-> $stable(func_out_o))
        else $error("function outputs moved during procedure");
    play_stop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && moving_i) |=> !play_trial_o)
        else $error("audition while moving");
    clear_end_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && !abort && press[csp_pkg::KEY_CLEAR]) |=>
        !active_reg && active_set_reg == csp_pkg::SEL_NONE && jingle_o == 2'h2)
        else $error("clear did not end and empty the selection");
    store_end_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && !abort && press[csp_pkg::KEY_STORE] && !press[csp_pkg::KEY_CLEAR])
        |=> !active_reg && active_set_reg == $past(trial_reg))
        else $error("store did not commit trial set");
    abort_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        abort |=> !active_reg && $stable(active_set_reg))
        else $error("abort lost old set");
    wrong_key_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && !abort && any_press && !valid_key) |=> jingle_o == 2'h1)
        else $error("wrong key gave no error jingle");
    end_list_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && !abort && press[csp_pkg::KEY_NEXT] && !press[csp_pkg::KEY_PREV]
        && at_last && !press[csp_pkg::KEY_CLEAR] && !press[csp_pkg::KEY_STORE])
        |=> jingle_o == 2'h1 && $stable(trial_reg))
        else $error("end of list not signalled");
    no_sample_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active_reg && !abort && valid_key && press[csp_pkg::KEY_PLAY]
        && trial_reg == csp_pkg::SEL_NONE && !press[csp_pkg::KEY_CLEAR]
        && !press[csp_pkg::KEY_STORE]) |=> jingle_o == 2'h1)
        else $error("empty play gave no error jingle");
    drive_pass_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        active_reg |=> speed_o == $past(speed_cmd_i) && dir_o == $past(dir_cmd_i))
        else $error("drive command blocked during procedure");
    func_back_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !active_reg |=> func_out_o == $past(func_keys_i))
        else $error("functions not restored");
endmodule // csp_chuff_select

//--- inc/csp_pkg.sv
/*
 * Constants and types for the chuff set selection interpreter.
 * Assumes one 40 MHz clock and decoded operations-mode writes from the packet decoder.
 */
package csp_pkg;
    localparam int ADDR_W = 14;
    localparam int CV_W = 10;
    localparam int NSETS_W = 5;
    localparam logic [CV_W-1:0] SOUND_ADJUST_CV = 10'h12C;
    localparam logic [7:0] ENTRY_VALUE = 8'h64;
    localparam logic [ADDR_W-1:0] BARRED_ADDR = 14'h0003;
    localparam logic [NSETS_W-1:0] SEL_NONE = 5'h00;
    localparam logic [NSETS_W-1:0] SEL_RESET = 5'h01;
    localparam int KEY_PLAY = 0;
    localparam int KEY_PREV = 1;
    localparam int KEY_NEXT = 2;
    localparam int KEY_CLEAR = 3;
    localparam int KEY_STORE = 8;
    localparam int NKEYS = 9;
    localparam int NFUNCS = 29;
    typedef enum logic [1:0] {
        CSP_JINGLE_NONE,
        CSP_JINGLE_ERROR,
        CSP_JINGLE_CONFIRM
    } csp_jingle_t;
endpackage

//--- hw/csp_key_edge.sv
/*
 * Rising edge detector for one function key.
 * Assumes the key level is synchronous to mclk_i.
 */
module csp_key_edge (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Key
    input wire logic key_i,
    output logic press_o
);
    logic key_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_reg <= 1'b0;
        end else begin
            key_reg <= key_i;
        end
    end

    assign press_o = key_i & ~key_reg;
endmodule // csp_key_edge

//--- verif/csp_cab_model.sv
/*
 * Model of the command station and cab that face the chuff set interpreter.
 * Assumes the caller runs its tasks from one process, clocked by mclk_i.
 */
module csp_cab_model (
    // Clock
    input wire logic mclk_i,
    // Programming writes
    output logic ops_write_o,
    output logic service_write_o,
    output logic [csp_pkg::CV_W-1:0] write_cv_o,
    output logic [7:0] write_value_o,
    output logic [csp_pkg::ADDR_W-1:0] loco_addr_o,
    // Keys and drive
    output logic [csp_pkg::NFUNCS-1:0] func_keys_o,
    output logic [7:0] speed_cmd_o,
    output logic dir_cmd_o,
    output logic manual_override_key_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ops_write_o = 1'b0;
        service_write_o = 1'b0;
        write_cv_o = 10'h000;
        write_value_o = 8'h00;
        loco_addr_o = 14'h0010;
        func_keys_o = '0;
        speed_cmd_o = 8'h00;
        dir_cmd_o = 1'b0;
        manual_override_key_o = 1'b0;
    end

    // Address and drive levels are owned here so each has one driver.
    task automatic set_addr(input logic [csp_pkg::ADDR_W-1:0] a);
        loco_addr_o = a;
    endtask

    task automatic drive(input logic [7:0] spd, input logic dir, input logic man);
        speed_cmd_o = spd;
        dir_cmd_o = dir;
        manual_override_key_o = man;
    endtask

    // Service mode is only used when a scenario asks for it on purpose.
    task automatic prog_write(input logic svc, input logic [csp_pkg::CV_W-1:0] cv,
                              input logic [7:0] val);
        @(posedge mclk_i);
        #2;
        ops_write_o = ~svc;
        service_write_o = svc;
        write_cv_o = cv;
        write_value_o = val;
        @(posedge mclk_i);
        #2;
        ops_write_o = 1'b0;
        service_write_o = 1'b0;
        // A released bus shows the inverse so stale data cannot pass for valid.
        write_cv_o = ~cv;
        write_value_o = ~val;
    endtask

    task automatic press(input int n, input int hold);
        @(posedge mclk_i);
        #2;
        func_keys_o[n] = 1'b1;
        repeat (hold) @(posedge mclk_i);
        #2;
        func_keys_o[n] = 1'b0;
    endtask
endmodule // csp_cab_model

//--- verif/tb_csp_chuff_select.sv
/*
 * Self-checking bench for the chuff set selection interpreter.
 * Assumes the cab model drives writes and keys; steam, motion and set count come from here.
 */
module tb_csp_chuff_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] J_ERR = csp_pkg::CSP_JINGLE_ERROR;
    localparam logic [1:0] J_OK = csp_pkg::CSP_JINGLE_CONFIRM;
    logic mclk_i, rstn_i, project_is_steam_i, moving_i;
    logic [csp_pkg::NSETS_W-1:0] stored_sets_i, active_set_o, trial_set_o;
    logic ops_write, service_write, dir_cmd, manual_override_key, dir_o, manual_override_o;
    logic [csp_pkg::CV_W-1:0] write_cv;
    logic [7:0] write_value, speed_cmd, speed_o;
    logic [csp_pkg::ADDR_W-1:0] loco_addr;
    logic [csp_pkg::NFUNCS-1:0] func_keys, func_out_o;
    logic active_o, play_trial_o;
    logic [1:0] jingle_o;
    int mismatches, total_checks;

    csp_cab_model u_csp_cab_model (.mclk_i(mclk_i), .ops_write_o(ops_write),
        .service_write_o(service_write), .write_cv_o(write_cv), .write_value_o(write_value),
        .loco_addr_o(loco_addr), .func_keys_o(func_keys), .speed_cmd_o(speed_cmd),
        .dir_cmd_o(dir_cmd), .manual_override_key_o(manual_override_key));

    csp_chuff_select #(.NUM_SETS(5)) u_csp_chuff_select (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .ops_write_i(ops_write), .service_write_i(service_write), .write_cv_i(write_cv),
        .write_value_i(write_value), .loco_addr_i(loco_addr),
        .project_is_steam_i(project_is_steam_i), .moving_i(moving_i),
        .stored_sets_i(stored_sets_i), .func_keys_i(func_keys), .speed_cmd_i(speed_cmd),
        .dir_cmd_i(dir_cmd), .manual_override_key_i(manual_override_key), .func_out_o(func_out_o),
        .speed_o(speed_o), .dir_o(dir_o), .manual_override_o(manual_override_o),
        .active_o(active_o), .active_set_o(active_set_o), .trial_set_o(trial_set_o),
        .play_trial_o(play_trial_o), .jingle_o(jingle_o));

    task automatic check_vec(input logic [28:0] got, input logic [28:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic enter();
        u_csp_cab_model.prog_write(1'b0, csp_pkg::SOUND_ADJUST_CV, csp_pkg::ENTRY_VALUE);
    endtask

    task automatic key(input int n);
        u_csp_cab_model.press(n, 1);
    endtask

    task automatic t_entry_gates();
        project_is_steam_i = 1'b0;
        enter();
        check_vec(active_o, 0, "diesel entry");
        project_is_steam_i = 1'b1;
        u_csp_cab_model.set_addr(csp_pkg::BARRED_ADDR);
        enter();
        check_vec(active_o, 0, "address 3 entry");
        u_csp_cab_model.set_addr(14'h0010);
    endtask

    task automatic t_step_store();
        enter();
        check_vec(active_o, 1, "entry");
        check_vec(trial_set_o, csp_pkg::SEL_RESET, "trial at entry");
        key(csp_pkg::KEY_PREV);
        check_vec(jingle_o, J_ERR, "prev at first");
        key(csp_pkg::KEY_NEXT);
        check_vec(trial_set_o, 5'h02, "next");
        check_vec(play_trial_o, 1, "next plays");
        key(csp_pkg::KEY_NEXT);
        key(csp_pkg::KEY_NEXT);
        check_vec(jingle_o, J_ERR, "next at last");
        check_vec(trial_set_o, 5'h03, "held at last");
        moving_i = 1'b1;
        key(csp_pkg::KEY_PREV);
        check_vec(trial_set_o, 5'h02, "prev moving");
        check_vec(play_trial_o, 0, "no audition moving");
        key(csp_pkg::KEY_PLAY);
        check_vec(play_trial_o, 0, "play moving");
        moving_i = 1'b0;
        key(csp_pkg::KEY_PLAY);
        check_vec(play_trial_o, 1, "play stopped");
        for (int k = 4; k < 8; k++) begin
            key(k);
            check_vec(jingle_o, J_ERR, "wrong key");
            check_vec(func_out_o, 0, "frozen outputs");
        end
        check_vec(active_set_o, csp_pkg::SEL_RESET, "set during");
        u_csp_cab_model.drive(8'h5A, 1'b1, 1'b1);
        @(posedge mclk_i);
        #2;
        check_vec({speed_o, dir_o, manual_override_o}, 10'h16B, "drive");
        key(csp_pkg::KEY_STORE);
        check_vec(active_o, 0, "store ends");
        check_vec(active_set_o, 5'h02, "store set");
        check_vec(jingle_o, J_OK, "store jingle");
        u_csp_cab_model.press(5, 2);
        check_vec(func_out_o, 29'h20, "outputs back");
    endtask

    task automatic t_clear_abort();
        enter();
        key(csp_pkg::KEY_CLEAR);
        check_vec(active_o, 0, "clear ends");
        check_vec(active_set_o, csp_pkg::SEL_NONE, "clear set");
        check_vec(jingle_o, J_OK, "clear jingle");
        enter();
        key(csp_pkg::KEY_PLAY);
        check_vec(jingle_o, J_ERR, "play no sample");
        u_csp_cab_model.prog_write(1'b0, csp_pkg::SOUND_ADJUST_CV, 8'h00);
        check_vec(active_o, 0, "zero write");
        check_vec(active_set_o, csp_pkg::SEL_NONE, "set kept");
        enter();
        u_csp_cab_model.prog_write(1'b1, 10'h001, 8'h05);
        check_vec(active_o, 0, "service write");
        enter();
        rstn_i = 1'b0;
        @(posedge mclk_i);
        #2;
        check_vec(active_o, 0, "power loss");
        rstn_i = 1'b1;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    initial begin
        #100000;
        mismatches++;
        complete_run();
    end

    initial begin
        mismatches = 0;
        total_checks = 0;
        rstn_i = 1'b0;
        project_is_steam_i = 1'b1;
        moving_i = 1'b0;
        stored_sets_i = 5'h03;
        repeat (16) @(posedge mclk_i);
        #2;
        rstn_i = 1'b1;
        check_vec(active_set_o, csp_pkg::SEL_RESET, "reset set");
        t_entry_gates();
        t_step_store();
        t_clear_abort();
        complete_run();
    end
endmodule // tb_csp_chuff_select
